// ---- design/crg_cfg.svh ----
// timing counts, reset values and phase constants of the clock and ready generator
`ifndef CRG_CFG_SVH
`define CRG_CFG_SVH

// reset values of output and state flops
`define CRG_OE_RST 1'b1
`define CRG_LVL_RST 1'b0
`define CRG_PAIR_RST 2'b00
`define CRG_STAT_RST 2'b11

// core-clock cycles after reset release before the strap is caught
`define CRG_STRAP_LAST 2'd2

// ticks from cycle start: last tick of the status state, and ticks before ready is sampled
`define CRG_TS_LAST 2'd1
`define CRG_REL_TICKS 3'd3
`define CRG_TICK_MAX 3'd7

// peripheral clock level forced at the first bus cycle start after reset
`define CRG_PCLK_ALIGN 1'b1

`endif

// ---- design/crg_pkg.sv ----
// types shared by the clock and ready generator modules
package crg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_CMD_P1,
    ST_CMD_P2,
    ST_HELD
  } crg_rdy_state_t;

  typedef enum logic {
    SRC_CRYSTAL,
    SRC_EXTERNAL
  } crg_src_t;

endpackage

// ---- design/crg_rdy_if.sv ----
// link between the clock front end and the ready qualifier
`timescale 1ns/1ps
interface crg_rdy_if (
  input wire logic clk,
  input wire logic rst
);
  logic tick;
  logic cycle_start;
  logic sync_ready_n;
  logic sync_enable_n;
  logic async_ready_n;
  logic async_enable_n;
  logic pull;
  logic async_won;

  modport ctl (
    input clk, rst, pull, async_won,
    output tick, cycle_start, sync_ready_n, sync_enable_n, async_ready_n, async_enable_n
  );
  modport qual (
    input clk, rst, tick, cycle_start, sync_ready_n, sync_enable_n, async_ready_n,
    input async_enable_n,
    output pull, async_won
  );
endinterface

// ---- design/crg_ready_qual.sv ----
// ready qualifier: sequences the command state and decides when ready is pulled low
`timescale 1ns/1ps
`include "crg_cfg.svh"
module crg_ready_qual (
  crg_rdy_if.qual rif
);

  crg_pkg::crg_rdy_state_t state_r;
  logic [1:0] ts_cnt_r;
  logic async_hit_r;
  logic pull_r;
  logic async_won_r;
  logic async_ok;
  logic sync_ok;

  // an input counts only while its own enable is low
  assign async_ok = ~rif.async_enable_n & ~rif.async_ready_n;
  assign sync_ok = ~rif.sync_enable_n & ~rif.sync_ready_n;

  assign rif.pull = pull_r;
  assign rif.async_won = async_won_r;

  // all steps happen on system-clock falling edges (tick)
  always_ff @(posedge rif.clk or posedge rif.rst) begin
    if (rif.rst) begin
      state_r <= crg_pkg::ST_IDLE;
      ts_cnt_r <= `CRG_PAIR_RST;
      async_hit_r <= `CRG_LVL_RST;
      pull_r <= `CRG_LVL_RST;
      async_won_r <= `CRG_LVL_RST;
    end else if (rif.tick) begin
      if (rif.cycle_start) begin
        // float ready so the pull-up can restore it
        state_r <= crg_pkg::ST_SETTLE;
        ts_cnt_r <= `CRG_PAIR_RST;
        pull_r <= 1'b0;
        async_won_r <= 1'b0;
        async_hit_r <= 1'b0;
      end else begin
        case (state_r)
          crg_pkg::ST_SETTLE: begin
            ts_cnt_r <= ts_cnt_r + 2'd1;
            if (ts_cnt_r == `CRG_TS_LAST) begin
              // async ready taken at command start, resolved over one cycle
              async_hit_r <= async_ok;
              state_r <= crg_pkg::ST_CMD_P1;
            end
          end
          crg_pkg::ST_CMD_P1: begin
            if (async_hit_r) begin
              pull_r <= 1'b1;
              async_won_r <= 1'b1;
              state_r <= crg_pkg::ST_HELD;
            end else if (sync_ok) begin
              // sync ready taken at end of phase 1
              pull_r <= 1'b1;
              state_r <= crg_pkg::ST_HELD;
            end else begin
              // neither enabled input active: one more command state
              state_r <= crg_pkg::ST_CMD_P2;
            end
          end
          crg_pkg::ST_CMD_P2: begin
            async_hit_r <= async_ok;
            state_r <= crg_pkg::ST_CMD_P1;
          end
          crg_pkg::ST_HELD: begin
            // sync input is disregarded once async has won
            if (async_won_r ? (~rif.async_enable_n & rif.async_ready_n)
                            : (~rif.sync_enable_n & rif.sync_ready_n)) begin
              pull_r <= 1'b0;
            end
          end
          crg_pkg::ST_IDLE: begin
            pull_r <= 1'b0;
          end
          default: begin
            state_r <= crg_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  a_start_floats: assert property (@(posedge rif.clk) disable iff (rif.rst)
    rif.tick && rif.cycle_start |=> !pull_r && state_r == crg_pkg::ST_SETTLE)
    else $error("ready not released at cycle start");

  a_wait_insert: assert property (@(posedge rif.clk) disable iff (rif.rst)
    rif.tick && !rif.cycle_start && state_r == crg_pkg::ST_CMD_P1 && !async_hit_r && !sync_ok
    |=> !pull_r && state_r == crg_pkg::ST_CMD_P2)
    else $error("wait state not inserted");

  a_sync_pull: assert property (@(posedge rif.clk) disable iff (rif.rst)
    rif.tick && !rif.cycle_start && state_r == crg_pkg::ST_CMD_P1 && sync_ok
    |=> pull_r)
    else $error("enabled sync ready did not pull ready low");

  a_async_sync_ign: assert property (@(posedge rif.clk) disable iff (rif.rst)
    state_r == crg_pkg::ST_HELD && async_won_r && rif.tick && !rif.cycle_start
    && async_ok |=> pull_r)
    else $error("sync ready not ignored after async win");

  a_release_high: assert property (@(posedge rif.clk) disable iff (rif.rst)
    state_r == crg_pkg::ST_HELD && !async_won_r && rif.tick && !rif.cycle_start
    && !rif.sync_enable_n && rif.sync_ready_n |=> !pull_r)
    else $error("ready not released on enabled input high");

  c_wait_state: cover property (@(posedge rif.clk) disable iff (rif.rst)
    state_r == crg_pkg::ST_CMD_P2 && rif.tick);
  c_async_end: cover property (@(posedge rif.clk) disable iff (rif.rst) $rose(async_won_r));

endmodule

// ---- design/crg_clock_ready_gen.sv ----
// clock and ready generator: system and peripheral clocks, open-collector ready
`timescale 1ns/1ps
`include "crg_cfg.svh"
// Notes on behaviour
// - strap low selects crystal source
// - strap high selects external frequency input
// - system clock duty follows the source, peripheral clock 50% duty
// - peripheral clock is half system clock
// - peripheral clock aligned at first bus cycle
// - ready high ends command adds wait
// - ready low before closing edge ends cycle
// - wait only when both inputs inactive/disabled
// - async win ignores sync until cycle end
// - ready floated at each bus cycle start
// - three system cycles before ready sampled
// - enabled active input pulls ready low
// - ready low until new cycle or input high
// - ready held low during reset
// - sync ready sampled end of phase one
// - async ready sampled one cycle earlier
module crg_clock_ready_gen (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // frequency sources and strap
  input wire logic crystal_pin_a_i,
  output logic crystal_pin_b_o,
  input wire logic external_frequency_input_i,
  input wire logic src_select_i,
  // bus status, active low
  input wire logic bus_status_low_bit_n_i,
  input wire logic bus_status_high_bit_n_i,
  // ready inputs and enables, active low
  input wire logic sync_ready_in_n_i,
  input wire logic sync_ready_enable_n_i,
  input wire logic async_ready_in_n_i,
  input wire logic async_ready_enable_n_i,
  // open-collector ready line
  input wire logic ready_n_i,
  output logic ready_n_o,
  output logic ready_n_oe_o,
  // clock outputs
  output logic sys_clk_o,
  output logic pclk_o
);

  // two-flop synchronisers, one bit per pin
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_s1_r;
  logic [NSYNC-1:0] pin_s2_r;
  logic [NSYNC-1:0] pin_raw;

  logic xtal_s;
  logic efi_s;
  logic strap_s;
  logic st0_s;
  logic st1_s;
  logic sync_ready_in_s;
  logic sren_s;
  logic async_ready_in_s;
  logic aren_s;
  logic line_s;

  crg_pkg::crg_src_t src_sel_r;
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  logic src_lvl;
  logic src_prev_r;
  logic sys_clk_r;
  logic sys_rise;
  logic sys_fall;
  logic pclk_r;
  logic aligned_r;
  logic [1:0] stat_prev_r;
  logic cycle_start;
  logic ready_oe_r;
  logic ready_out_r;
  logic xtal_drv_r;
  logic [2:0] tick_cnt_r;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  assign pin_raw = {ready_n_i, async_ready_enable_n_i, async_ready_in_n_i,
                    sync_ready_enable_n_i, sync_ready_in_n_i, bus_status_high_bit_n_i,
                    bus_status_low_bit_n_i, src_select_i, external_frequency_input_i,
                    crystal_pin_a_i};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign xtal_s = pin_s2_r[0];
  assign efi_s = pin_s2_r[1];
  assign strap_s = pin_s2_r[2];
  assign st0_s = pin_s2_r[3];
  assign st1_s = pin_s2_r[4];
  assign sync_ready_in_s = pin_s2_r[5];
  assign sren_s = pin_s2_r[6];
  assign async_ready_in_s = pin_s2_r[7];
  assign aren_s = pin_s2_r[8];
  assign line_s = pin_s2_r[9];

  // strap caught once after reset release, once the synchroniser holds the pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_r <= `CRG_PAIR_RST;
      strap_done_r <= `CRG_LVL_RST;
      src_sel_r <= crg_pkg::SRC_CRYSTAL;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'd1;
      if (strap_cnt_r == `CRG_STRAP_LAST) begin
        strap_done_r <= 1'b1;
        src_sel_r <= strap_s ? crg_pkg::SRC_EXTERNAL : crg_pkg::SRC_CRYSTAL;
      end
    end
  end

  // source must already run at the system clock rate, twice the processor rate; no divide here
  assign src_lvl = (src_sel_r == crg_pkg::SRC_EXTERNAL) ? efi_s : xtal_s;

  // inverting drive back to the crystal keeps the oscillator loop closed
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_drv_r <= `CRG_LVL_RST;
    end else begin
      xtal_drv_r <= ~xtal_s;
    end
  end

  // system clock follows the source, so its duty matches the source's
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_clk_r <= `CRG_LVL_RST;
      src_prev_r <= `CRG_LVL_RST;
    end else begin
      sys_clk_r <= strap_done_r & src_lvl;
      src_prev_r <= sys_clk_r;
    end
  end

  assign sys_rise = ~src_prev_r & sys_clk_r;
  assign sys_fall = fell(src_prev_r, sys_clk_r);

  // status sampled on system-clock falling edges
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_prev_r <= `CRG_STAT_RST;
    end else if (sys_fall) begin
      stat_prev_r <= {st1_s, st0_s};
    end
  end

  assign cycle_start = sys_fall & (fell(stat_prev_r[0], st0_s) | fell(stat_prev_r[1], st1_s));

  // peripheral clock: toggles per system rise, forced once to the processor phase
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pclk_r <= `CRG_LVL_RST;
      aligned_r <= `CRG_LVL_RST;
    end else if (cycle_start && !aligned_r) begin
      pclk_r <= `CRG_PCLK_ALIGN;
      aligned_r <= 1'b1;
    end else if (sys_rise) begin
      pclk_r <= ~pclk_r;
    end
  end

  crg_rdy_if rif (
    .clk(core_clk_i),
    .rst(rst_i)
  );

  assign rif.tick = sys_fall;
  assign rif.cycle_start = cycle_start;
  assign rif.sync_ready_n = sync_ready_in_s;
  assign rif.sync_enable_n = sren_s;
  assign rif.async_ready_n = async_ready_in_s;
  assign rif.async_enable_n = aren_s;

  crg_ready_qual u_qual (
    .rif(rif.qual)
  );

  // ready driven low through reset so the bus controller idles
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_oe_r <= `CRG_OE_RST;
      ready_out_r <= `CRG_LVL_RST;
    end else begin
      ready_oe_r <= rif.pull;
      ready_out_r <= `CRG_LVL_RST;
    end
  end

  // ticks since the last cycle start, saturating; only the checks read it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
    end else if (cycle_start) begin
      tick_cnt_r <= '0;
    end else if (sys_fall && tick_cnt_r != `CRG_TICK_MAX) begin
      tick_cnt_r <= tick_cnt_r + 3'd1;
    end
  end

  assign crystal_pin_b_o = xtal_drv_r;
  assign sys_clk_o = sys_clk_r;
  assign pclk_o = pclk_r;
  assign ready_n_o = ready_out_r;
  assign ready_n_oe_o = ready_oe_r;

  a_reset_ready_low: assert property (@(posedge core_clk_i)
    rst_i |-> ready_n_oe_o)
    else $error("ready not driven low in reset");

  a_release_window: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ready_n_oe_o) |-> tick_cnt_r >= `CRG_REL_TICKS)
    else $error("ready pulled before three system cycles");

  a_start_float: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cycle_start |-> ##2 !ready_n_oe_o)
    else $error("ready line not floated after cycle start");

  a_pclk_toggle: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sys_rise && !cycle_start |=> pclk_o != $past(pclk_o))
    else $error("peripheral clock missed a system rise");

  a_pclk_steady: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !sys_rise && !(cycle_start && !aligned_r) |=> $stable(pclk_o))
    else $error("peripheral clock moved off a system rise");

  a_pclk_align: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cycle_start && !aligned_r |=> pclk_o == `CRG_PCLK_ALIGN && aligned_r)
    else $error("peripheral clock not aligned at first cycle");

  a_src_crystal: assert property (@(posedge core_clk_i) disable iff (rst_i)
    strap_done_r && src_sel_r == crg_pkg::SRC_CRYSTAL |=> sys_clk_o == $past(xtal_s))
    else $error("crystal not used as source");

  a_src_external: assert property (@(posedge core_clk_i) disable iff (rst_i)
    strap_done_r && src_sel_r == crg_pkg::SRC_EXTERNAL |=> sys_clk_o == $past(efi_s))
    else $error("external input not used as source");

  a_pull_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ready_n_oe_o && !$past(sys_fall) && !$past(rst_i) |=> ready_n_oe_o)
    else $error("ready released off a system falling edge");

  c_sync_end: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ready_n_oe_o) && !rif.async_won);
  c_align: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(aligned_r));
  c_line_low: cover property (@(posedge core_clk_i) disable iff (rst_i)
    ready_n_oe_o && !line_s);

endmodule

// ---- verification/crg_bus_partner.sv ----
// bus-side model: processor status, wait-state logic, ready inputs
`timescale 1ns/1ps
module crg_bus_partner (
  // observed clocks and ready drive
  input wire logic core_clk_i,
  input wire logic sys_clk_i,
  input wire logic pclk_i,
  input wire logic oe_i,
  // status and ready inputs into the generator
  output logic st_lo_n_o,
  output logic st_hi_n_o,
  output logic sync_ready_in_n_o,
  output logic sync_ready_in_en_n_o,
  output logic async_ready_in_n_o,
  output logic async_ready_in_en_n_o
);
  int falls = 0;
  logic sys_q = 1'b0;

  initial begin
    {st_lo_n_o, st_hi_n_o, sync_ready_in_n_o, sync_ready_in_en_n_o, async_ready_in_n_o, async_ready_in_en_n_o} = 6'h3f;
  end

  // system falls seen at core edges, one per tick of the generator
  always @(posedge core_clk_i) begin
    sys_q <= sys_clk_i;
    if (sys_q === 1'b1 && sys_clk_i === 1'b0) begin
      falls <= falls + 1;
    end
  end

  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic wait_sys(input logic v);
    int n;
    n = 0;
    while (sys_clk_i !== v && n < 100) begin
      step();
      n++;
    end
  endtask

  task automatic wait_falls(input int f);
    int n;
    n = 0;
    while (falls < f && n < 300) begin
      step();
      n++;
    end
  endtask

  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    while (oe_i !== v && n < lim) begin
      step();
      n++;
    end
  endtask

  task automatic bus_cycle(input int k, input bit as, input logic [1:0] st, input bit hold,
                           input bit rel, output int f_start, output int f_end,
                           output logic stay, output int rel_n, output logic pclk_seen);
    int f0;
    int n;
    wait_sys(1'b0);
    wait_sys(1'b1);
    f0 = falls;
    // status set after a rise so it is settled at the next fall
    st_lo_n_o = st[0];
    st_hi_n_o = st[1];
    wait_falls(f0 + 1);
    step();
    step();
    pclk_seen = pclk_i;
    wait_oe(1'b0, 60, n);
    f_start = falls - f0;
    st_lo_n_o = 1'b1;
    st_hi_n_o = 1'b1;
    // one input enabled, the other low but disabled
    sync_ready_in_en_n_o = as;
    sync_ready_in_n_o = !as;
    async_ready_in_en_n_o = !as;
    async_ready_in_n_o = as;
    // wait states: input goes active just before its deciding sample
    wait_falls(f0 + 2 * k + 2 + int'(!as));
    if (as) begin
      async_ready_in_n_o = 1'b0;
    end else begin
      sync_ready_in_n_o = 1'b0;
    end
    wait_oe(1'b1, 200, n);
    f_end = falls - f0;
    stay = 1'b1;
    if (hold) begin
      sync_ready_in_en_n_o = 1'b0;
      sync_ready_in_n_o = 1'b1;
      repeat (36) begin
        step();
        if (oe_i !== 1'b1) begin
          stay = 1'b0;
        end
      end
      sync_ready_in_en_n_o = 1'b1;
      sync_ready_in_n_o = 1'b0;
    end
    rel_n = 0;
    // ready line is shared; only the owner's input ends the cycle
    if (rel) begin
      if (as) begin
        async_ready_in_n_o = 1'b1;
      end else begin
        sync_ready_in_n_o = 1'b1;
      end
      wait_oe(1'b0, 60, rel_n);
    end
  endtask
endmodule

// ---- verification/test_crg_clock_ready_gen.sv ----
// self-checking bench for the clock and ready generator
`timescale 1ns/1ps
`include "crg_cfg.svh"
module test_crg_clock_ready_gen;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic crystal_pin_a_i = 1'b0;
  logic external_frequency_input_i = 1'b0;
  logic src_select_i = 1'b0;
  logic st_lo_n, st_hi_n, sync_ready_in_n, sync_ready_in_en_n, async_ready_in_n, async_ready_in_en_n;
  logic ready_n_o, ready_n_oe_o, sys_clk_o, pclk_o, crystal_pin_b_o;
  logic ready_line;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  always #25 core_clk_i = ~core_clk_i;
  // two sources at different rates so the strap choice shows
  always begin
    repeat (4) @(posedge core_clk_i);
    #1 crystal_pin_a_i = ~crystal_pin_a_i;
  end
  always begin
    repeat (6) @(posedge core_clk_i);
    #1 external_frequency_input_i = ~external_frequency_input_i;
  end
  // pull-up on the open-collector line
  assign ready_line = ready_n_oe_o ? ready_n_o : 1'b1;

  crg_clock_ready_gen crg_clock_ready_gen_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .crystal_pin_a_i(crystal_pin_a_i), .crystal_pin_b_o(crystal_pin_b_o),
    .external_frequency_input_i(external_frequency_input_i), .src_select_i(src_select_i),
    .bus_status_low_bit_n_i(st_lo_n), .bus_status_high_bit_n_i(st_hi_n),
    .sync_ready_in_n_i(sync_ready_in_n), .sync_ready_enable_n_i(sync_ready_in_en_n),
    .async_ready_in_n_i(async_ready_in_n), .async_ready_enable_n_i(async_ready_in_en_n),
    .ready_n_i(ready_line), .ready_n_o(ready_n_o), .ready_n_oe_o(ready_n_oe_o),
    .sys_clk_o(sys_clk_o), .pclk_o(pclk_o)
  );

  crg_bus_partner crg_bus_partner_i (
    .core_clk_i(core_clk_i), .sys_clk_i(sys_clk_o), .pclk_i(pclk_o), .oe_i(ready_n_oe_o),
    .st_lo_n_o(st_lo_n), .st_hi_n_o(st_hi_n), .sync_ready_in_n_o(sync_ready_in_n), .sync_ready_in_en_n_o(sync_ready_in_en_n),
    .async_ready_in_n_o(async_ready_in_n), .async_ready_in_en_n_o(async_ready_in_en_n)
  );

  task automatic final_report();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // far above the expected run of a few thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask

  function automatic logic pick(input bit p);
    return p ? pclk_o : sys_clk_o;
  endfunction

  task automatic run_len(input bit p, output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    while (pick(p) !== 1'b0 && n < 100) begin step(); n++; end
    while (pick(p) !== 1'b1 && n < 200) begin step(); n++; end
    while (pick(p) === 1'b1 && n < 300) begin step(); n++; hi++; end
    while (pick(p) === 1'b0 && n < 400) begin step(); n++; lo++; end
  endtask

  task automatic session(input logic sel, input int h);
    int hi, lo, k, st0, len, rel_n;
    logic pc, stay;
    logic [1:0] st;
    bit as;
    rst_i = 1'b1;
    src_select_i = sel;
    repeat (20) step();
    chk(16'(ready_n_oe_o), 16'h0001);
    chk(16'(ready_n_o), 16'h0000);
    chk(16'({crystal_pin_b_o, sys_clk_o, pclk_o}), 16'h0000);
    rst_i = 1'b0;
    repeat (30) step();
    run_len(1'b0, hi, lo);
    chk(16'(hi), 16'(h));
    chk(16'(lo), 16'(h));
    run_len(1'b1, hi, lo);
    chk(16'(hi), 16'(2 * h));
    chk(16'(lo), 16'(2 * h));
    for (int i = 0; i < 12; i++) begin
      // first six cover every status pattern, wait count and input
      k = (i < 6) ? i % 3 : int'($urandom_range(2));
      as = (i < 6) ? (i >= 3) : 1'($urandom_range(1));
      st = (i < 6) ? 2'(i % 3) : 2'($urandom_range(2));
      crg_bus_partner_i.bus_cycle(k, as, st, as, i == 11, st0, len, stay, rel_n, pc);
      chk(16'(st0), 16'h0001);
      if (i == 0) begin
        chk(16'(pc), 16'(`CRG_PCLK_ALIGN));
      end
      chk(16'(len), 16'(2 * k + 4));
      if (as) begin
        chk(16'(stay), 16'h0001);
      end
      if (i == 11) begin
        chk(16'(rel_n < 60), 16'h0001);
      end
    end
  endtask

  initial begin
    void'($urandom(32'h0335511e));
    // reset raised off time zero so the design sees a clean edge
    #1;
    session(1'b0, 4);
    session(1'b1, 6);
    final_report();
  end
endmodule
